// ==== rtl/dbg_cmp_cfg.svh ====
// Offsets, field positions and reset values of the debug comparators
`ifndef DBG_CMP_CFG_SVH
`define DBG_CMP_CFG_SVH

// Widths
`define REG_ADDR_W      16
`define BUS_ADDR_W      24
`define BUS_DATA_W      32
`define IRQ_W           3

// Register byte offsets
`define OFS_CTRL        16'h0100
`define OFS_STATUS      16'h0101
`define OFS_IRQ_STATUS  16'h0102
`define OFS_IRQ_MASK    16'h0103
`define OFS_A_ADDR_HIGH 16'h0115
`define OFS_A_ADDR_MID  16'h0116
`define OFS_A_ADDR_LOW  16'h0117
`define OFS_A_DATA_0    16'h0118
`define OFS_A_DATA_1    16'h0119
`define OFS_A_DATA_2    16'h011A
`define OFS_A_DATA_3    16'h011B
`define OFS_A_MASK_0    16'h011C
`define OFS_A_MASK_1    16'h011D
`define OFS_A_MASK_2    16'h011E
`define OFS_A_MASK_3    16'h011F
`define OFS_B_CTRL      16'h0120

// Field positions
`define B_PC_ADDRESS_SELECT_BIT      5
`define B_RW_BIT        3
`define B_RWE_BIT       2
`define B_COMPARATOR_ENABLE_BIT     0
`define B_CTRL_WMASK    8'h2D
`define CTRL_ARM_BIT    0
`define CTRL_MODE_LSB   1
`define CTRL_MODE_MSB   2
`define STAT_PROF_BIT   4
`define STAT_ARM_BIT    0
`define IRQ_A_BIT       0
`define IRQ_B_BIT       1
`define IRQ_R_BIT       2
`define MODE_RANGE      2'h1

// Reset values
`define RST_BYTE        8'h00
`define RST_ADDR        24'h000000
`define RST_DATA        32'h00000000
`define RST_MASK        32'h00000000
`define RST_MODE        2'h0
`define RST_IRQ         3'h0

`endif

// ==== rtl/dbg_cmp_pkg.sv ====
// Types shared by the debug comparator files
package dbg_cmp_pkg;
  `include "dbg_cmp_cfg.svh"

  typedef logic [`REG_ADDR_W-1:0] reg_addr_type;
  typedef logic [7:0]             byte_type;
  typedef logic [`BUS_ADDR_W-1:0] bus_addr_type;
  typedef logic [`BUS_DATA_W-1:0] bus_data_type;
  typedef logic [`IRQ_W-1:0]      irq_type;

  // Whole state of the comparator block
  typedef struct packed {
    bus_addr_type a_addr;
    bus_data_type a_data;
    bus_data_type a_mask;
    byte_type     b_ctl;
    logic         arm;
    logic [1:0]   mode;
    logic         prof_active;
    irq_type      irq_status;
    irq_type      irq_mask;
    byte_type     rd_data;
    logic         match_a;
    logic         match_b;
    logic         match_range;
  } cmp_state_type;
endpackage

// ==== rtl/cmp_a_match.sv ====
// Bitwise address and masked data compare of comparator A
`timescale 1ns/1ps
`include "dbg_cmp_cfg.svh"

module cmp_a_match (
  // Stored reference
  input  dbg_cmp_pkg::bus_addr_type addr_ref,
  input  dbg_cmp_pkg::bus_data_type data_ref,
  input  dbg_cmp_pkg::bus_data_type data_mask,
  // Monitored bus
  input  dbg_cmp_pkg::bus_addr_type addr_bus,
  input  dbg_cmp_pkg::bus_data_type data_bus,
  // Results
  output logic                      addr_hit,
  output logic                      data_hit
);
  import dbg_cmp_pkg::*;

  logic [`BUS_ADDR_W-1:0] addr_bit_hit;
  logic [`BUS_DATA_W-1:0] data_bit_hit;

  // Per address bit: stored 0 expects 0, stored 1 expects 1
  for (genvar i = 0; i < `BUS_ADDR_W; i++) begin : g_addr
    assign addr_bit_hit[i] = (addr_bus[i] == addr_ref[i]);
  end

  // Per data bit: compared only where the mask bit is 1
  for (genvar j = 0; j < `BUS_DATA_W; j++) begin : g_data
    assign data_bit_hit[j] = !data_mask[j] ||
                             (data_bus[j] == data_ref[j]);
  end

  // Reduce to one hit each
  assign addr_hit = &addr_bit_hit;
  assign data_hit = &data_bit_hit;
endmodule

// ==== rtl/dbg_cmp_match.sv ====
// Debug comparators A and B: registers, match logic and interrupt
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "dbg_cmp_cfg.svh"

module dbg_cmp_match (
  // Clock and reset
  input  logic                      clk,
  input  logic                      arst_n,
  // Register port
  input  dbg_cmp_pkg::reg_addr_type reg_addr,
  input  dbg_cmp_pkg::byte_type     reg_wdata,
  input  logic                      reg_wr,
  input  logic                      reg_rd,
  output dbg_cmp_pkg::byte_type     reg_rdata,
  // Monitored processor bus
  input  logic                      bus_valid,
  input  logic                      bus_read,
  input  dbg_cmp_pkg::bus_addr_type bus_addr,
  input  dbg_cmp_pkg::bus_data_type bus_data,
  input  logic                      pc_valid,
  input  dbg_cmp_pkg::bus_addr_type pc_addr,
  // Comparator B reference address
  input  dbg_cmp_pkg::bus_addr_type cmp_b_address,
  // Profiling events
  input  logic                      prof_entry_start,
  input  logic                      prof_tx_end,
  // Results
  output logic                      match_a,
  output logic                      match_b,
  output logic                      match_range,
  output logic                      profiling_active_flag,
  output logic                      irq
);
  import dbg_cmp_pkg::*;

  cmp_state_type state_reg;
  cmp_state_type state_next;

  logic         wr_ok;
  logic         a_addr_hit;
  logic         a_data_hit;
  logic         range_mode;
  logic         b_pc_address_select;
  logic         b_rw;
  logic         b_rwe;
  logic         b_comparator_enable;
  logic         b_src_valid;
  bus_addr_type b_src_addr;
  logic         b_dir_ok;
  logic         hit_a;
  logic         hit_b;
  logic         hit_range;
  irq_type      events;
  irq_type      w1c;
  byte_type     rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // Comparator A bit compare
  cmp_a_match u_cmp_a (
    .addr_ref  (state_reg.a_addr),
    .data_ref  (state_reg.a_data),
    .data_mask (state_reg.a_mask),
    .addr_bus  (bus_addr),
    .data_bus  (bus_data),
    .addr_hit  (a_addr_hit),
    .data_hit  (a_data_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write permission
  assign wr_ok = !state_reg.arm && !state_reg.prof_active;

  // Comparator B control fields
  assign b_pc_address_select  = state_reg.b_ctl[`B_PC_ADDRESS_SELECT_BIT];
  assign b_rw    = state_reg.b_ctl[`B_RW_BIT];
  assign b_rwe   = state_reg.b_ctl[`B_RWE_BIT];
  assign b_comparator_enable = state_reg.b_ctl[`B_COMPARATOR_ENABLE_BIT];
  assign range_mode = (state_reg.mode == `MODE_RANGE);

  // Source of the address that B watches
  assign b_src_valid = b_pc_address_select ? pc_valid : bus_valid;
  assign b_src_addr  = b_pc_address_select ? pc_addr : bus_addr;

  // Direction qualifier, dropped for PC compare
  assign b_dir_ok = b_pc_address_select || !b_rwe || (bus_read == b_rw);

  // Match terms of this cycle
  assign hit_a = state_reg.arm && bus_valid && a_addr_hit && a_data_hit;
  assign hit_b = state_reg.arm && b_comparator_enable && !range_mode &&
                 b_src_valid && (b_src_addr == cmp_b_address) && b_dir_ok;
  assign hit_range = state_reg.arm && range_mode && bus_valid &&
                     (bus_addr >= state_reg.a_addr) &&
                     (bus_addr <= cmp_b_address);

  // Interrupt events and write-one-to-clear bits
  always_comb begin
    events = `RST_IRQ;
    events[`IRQ_A_BIT] = hit_a;
    events[`IRQ_B_BIT] = hit_b;
    events[`IRQ_R_BIT] = hit_range;
    w1c = `RST_IRQ;
    if (reg_wr && reg_addr == `OFS_IRQ_STATUS) begin
      w1c = reg_wdata[`IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer, unmapped reads give zero
  always_comb begin
    rd_byte = `RST_BYTE;
    case (reg_addr)
      `OFS_CTRL: begin
        rd_byte[`CTRL_ARM_BIT] = state_reg.arm;
        rd_byte[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = state_reg.mode;
      end
      `OFS_STATUS: begin
        rd_byte[`STAT_PROF_BIT] = state_reg.prof_active;
        rd_byte[`STAT_ARM_BIT]  = state_reg.arm;
      end
      `OFS_IRQ_STATUS: rd_byte[`IRQ_W-1:0] = state_reg.irq_status;
      `OFS_IRQ_MASK:   rd_byte[`IRQ_W-1:0] = state_reg.irq_mask;
      `OFS_A_ADDR_HIGH: rd_byte = state_reg.a_addr[23:16];
      `OFS_A_ADDR_MID:  rd_byte = state_reg.a_addr[15:8];
      `OFS_A_ADDR_LOW:  rd_byte = state_reg.a_addr[7:0];
      `OFS_A_DATA_0:    rd_byte = state_reg.a_data[31:24];
      `OFS_A_DATA_1:    rd_byte = state_reg.a_data[23:16];
      `OFS_A_DATA_2:    rd_byte = state_reg.a_data[15:8];
      `OFS_A_DATA_3:    rd_byte = state_reg.a_data[7:0];
      `OFS_A_MASK_0:    rd_byte = state_reg.a_mask[31:24];
      `OFS_A_MASK_1:    rd_byte = state_reg.a_mask[23:16];
      `OFS_A_MASK_2:    rd_byte = state_reg.a_mask[15:8];
      `OFS_A_MASK_3:    rd_byte = state_reg.a_mask[7:0];
      `OFS_B_CTRL:      rd_byte = state_reg.b_ctl;
      default:          rd_byte = `RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.rd_data = `RST_BYTE;
    if (reg_rd) begin
      state_next.rd_data = rd_byte;
    end
    // Arm and mask writable at any time
    if (reg_wr && reg_addr == `OFS_CTRL) begin
      state_next.arm = reg_wdata[`CTRL_ARM_BIT];
    end
    if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
      state_next.irq_mask = reg_wdata[`IRQ_W-1:0];
    end
    // Comparator setup only while disarmed and idle
    if (reg_wr && wr_ok) begin
      case (reg_addr)
        `OFS_CTRL: begin
          state_next.mode = reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        end
        `OFS_A_ADDR_HIGH: state_next.a_addr[23:16] = reg_wdata;
        `OFS_A_ADDR_MID:  state_next.a_addr[15:8]  = reg_wdata;
        `OFS_A_ADDR_LOW:  state_next.a_addr[7:0]   = reg_wdata;
        `OFS_A_DATA_0:    state_next.a_data[31:24] = reg_wdata;
        `OFS_A_DATA_1:    state_next.a_data[23:16] = reg_wdata;
        `OFS_A_DATA_2:    state_next.a_data[15:8]  = reg_wdata;
        `OFS_A_DATA_3:    state_next.a_data[7:0]   = reg_wdata;
        `OFS_A_MASK_0:    state_next.a_mask[31:24] = reg_wdata;
        `OFS_A_MASK_1:    state_next.a_mask[23:16] = reg_wdata;
        `OFS_A_MASK_2:    state_next.a_mask[15:8]  = reg_wdata;
        `OFS_A_MASK_3:    state_next.a_mask[7:0]   = reg_wdata;
        `OFS_B_CTRL: begin
          state_next.b_ctl = reg_wdata & `B_CTRL_WMASK;
        end
        default: begin
        end
      endcase
    end
    // Profiling flag, start wins over end
    if (prof_entry_start) begin
      state_next.prof_active = 1'b1;
    end else if (prof_tx_end) begin
      state_next.prof_active = 1'b0;
    end
    // Sticky status, a new event wins over the clear
    state_next.irq_status = (state_reg.irq_status & ~w1c) | events;
    // Registered match outputs
    state_next.match_a     = hit_a;
    state_next.match_b     = hit_b;
    state_next.match_range = hit_range;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.a_addr      <= `RST_ADDR;
      state_reg.a_data      <= `RST_DATA;
      state_reg.a_mask      <= `RST_MASK;
      state_reg.b_ctl       <= `RST_BYTE;
      state_reg.arm         <= 1'b0;
      state_reg.mode        <= `RST_MODE;
      state_reg.prof_active <= 1'b0;
      state_reg.irq_status  <= `RST_IRQ;
      state_reg.irq_mask    <= `RST_IRQ;
      state_reg.rd_data     <= `RST_BYTE;
      state_reg.match_a     <= 1'b0;
      state_reg.match_b     <= 1'b0;
      state_reg.match_range <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign reg_rdata             = state_reg.rd_data;
  assign match_a               = state_reg.match_a;
  assign match_b               = state_reg.match_b;
  assign match_range           = state_reg.match_range;
  assign profiling_active_flag = state_reg.prof_active;
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_WR_LOCKED: assert property (
    reg_wr && (state_reg.arm || state_reg.prof_active) &&
    reg_addr == `OFS_A_DATA_0 |=> $stable(state_reg.a_data))
    else $error("data value changed while write locked");

  AST_PROF_SET: assert property (
    prof_entry_start |=> profiling_active_flag)
    else $error("profiling flag not set on start");

  AST_PROF_CLR: assert property (
    prof_tx_end && !prof_entry_start |=> !profiling_active_flag)
    else $error("profiling flag not cleared on end");

  AST_A_ADDR: assert property (
    match_a |-> $past(bus_addr) == $past(state_reg.a_addr))
    else $error("comparator A matched a different address");

  AST_A_DATA: assert property (
    match_a |-> (($past(bus_data) ^ $past(state_reg.a_data)) &
                 $past(state_reg.a_mask)) == `RST_DATA)
    else $error("comparator A matched unequal masked data");

  AST_MASK_ZERO: assert property (
    state_reg.arm && bus_valid && bus_addr == state_reg.a_addr &&
    ((bus_data ^ state_reg.a_data) & state_reg.a_mask) == `RST_DATA
    |=> match_a)
    else $error("cleared mask blocked a match");

  AST_DATA_ORDER: assert property (
    reg_wr && wr_ok && reg_addr == `OFS_A_DATA_0 |=>
    state_reg.a_data[31:24] == $past(reg_wdata))
    else $error("data value byte order wrong");

  AST_MASK_ORDER: assert property (
    reg_wr && wr_ok && reg_addr == `OFS_A_MASK_3 |=>
    state_reg.a_mask[7:0] == $past(reg_wdata))
    else $error("data mask byte order wrong");

  AST_ADDR_ORDER: assert property (
    reg_wr && wr_ok && reg_addr == `OFS_A_ADDR_HIGH ##1 !reg_wr ##1
    reg_rd && reg_addr == `OFS_A_ADDR_HIGH |=>
    reg_rdata == $past(reg_wdata, 3))
    else $error("address high byte not read back");

  AST_B_PC: assert property (
    match_b && b_pc_address_select |-> $past(pc_valid) &&
    $past(pc_addr) == $past(cmp_b_address))
    else $error("PC match without PC address");

  AST_B_DIR: assert property (
    match_b && !b_pc_address_select && b_rwe |-> $past(bus_read) == b_rw)
    else $error("direction check let a wrong cycle match");

  AST_B_OFF: assert property (
    !b_comparator_enable && !reg_wr |=> !match_b)
    else $error("disabled comparator B matched");

  AST_RANGE_B: assert property (
    range_mode && !reg_wr |=> !match_b)
    else $error("comparator B matched in range mode");

  AST_RD_ONCE: assert property (
    !reg_rd |=> reg_rdata == `RST_BYTE)
    else $error("read data outside read answer cycle");

  AST_A_MISS: assert property (
    state_reg.arm && bus_valid &&
    ((bus_data ^ state_reg.a_data) & state_reg.a_mask) != `RST_DATA
    |=> !match_a)
    else $error("comparator A ignored an unequal masked-in bit");

  AST_A_ADDR_MISS: assert property (
    bus_addr != state_reg.a_addr |=> !match_a)
    else $error("comparator A matched with an address bit unequal");

  AST_B_DATA: assert property (
    match_b && !b_pc_address_select |-> $past(bus_valid) &&
    $past(bus_addr) == $past(cmp_b_address))
    else $error("data address match without data access");

  AST_B_NO_DIR: assert property (
    state_reg.arm && b_comparator_enable && !range_mode && !b_pc_address_select && !b_rwe &&
    bus_valid && bus_addr == cmp_b_address |=> match_b)
    else $error("direction blocked a match with checking off");

  AST_B_PC_DIR: assert property (
    state_reg.arm && b_comparator_enable && !range_mode && b_pc_address_select && pc_valid &&
    pc_addr == cmp_b_address |=> match_b)
    else $error("direction setting blocked a PC match");

  AST_RANGE_IN: assert property (
    match_range |-> $past(bus_addr) >= $past(state_reg.a_addr) &&
    $past(bus_addr) <= $past(cmp_b_address))
    else $error("range match outside the bounds");

  AST_PROF_HOLD: assert property (
    !prof_entry_start && !prof_tx_end |=> $stable(profiling_active_flag))
    else $error("profiling flag moved without an event");

  COV_A: cover property (match_a);
  COV_B_PC: cover property (match_b && b_pc_address_select);
  COV_RANGE: cover property (match_range ##1 irq);
  COV_LOCK: cover property (reg_wr && state_reg.prof_active);
  COV_B_DIR: cover property (match_b && b_rwe && !b_pc_address_select);
endmodule

// ==== verif/cpu_bus_model.sv ====
// Behavioural processor bus watched by the comparators
`timescale 1ns/1ps

module cpu_bus_model (
  // Clock
  input  logic                      clk,
  // Data access lines
  output logic                      bus_valid,
  output logic                      bus_read,
  output dbg_cmp_pkg::bus_addr_type bus_addr,
  output dbg_cmp_pkg::bus_data_type bus_data,
  // Program counter lines
  output logic                      pc_valid,
  output dbg_cmp_pkg::bus_addr_type pc_addr
);
  import dbg_cmp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Quiet bus at time zero
  initial begin
    bus_valid = 1'b0;
    bus_read  = 1'b0;
    bus_addr  = '0;
    bus_data  = '0;
    pc_valid  = 1'b0;
    pc_addr   = '0;
  end

  // Released lines show the inverse of their last value, never a stale hit
  task automatic drop;
    bus_valid <= 1'b0;
    pc_valid  <= 1'b0;
    bus_read  <= ~bus_read;
    bus_addr  <= ~bus_addr;
    bus_data  <= ~bus_data;
    pc_addr   <= ~pc_addr;
    @(posedge clk);
  endtask

  // One data access cycle, then release
  task automatic data_access(input logic rd, input bus_addr_type a,
                             input bus_data_type d);
    bus_valid <= 1'b1;
    bus_read  <= rd;
    bus_addr  <= a;
    bus_data  <= d;
    @(posedge clk);
    drop();
  endtask

  // One program counter cycle, then release
  task automatic pc_fetch(input bus_addr_type a);
    pc_valid <= 1'b1;
    pc_addr  <= a;
    @(posedge clk);
    drop();
  endtask
endmodule

// ==== verif/tb_debug_comparator_ab_match.sv ====
// Self-checking bench of the debug comparators
`timescale 1ns/1ps
`include "dbg_cmp_cfg.svh"

`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin \
  n_errors++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end end

module tb_debug_comparator_ab_match;
  import dbg_cmp_pkg::*;

  logic clk, arst_n, reg_wr, reg_rd, prof_entry_start, prof_tx_end;
  reg_addr_type reg_addr;
  byte_type     reg_wdata, reg_rdata, e8;
  logic bus_valid, bus_read, pc_valid, match_a, match_b, match_range;
  logic profiling_active_flag, irq, rd_seen, bus_seen;
  bus_addr_type bus_addr, pc_addr, cmp_b_address, aa, t;
  bus_data_type bus_data, ad, am;
  byte_type     sh [16'h0115:16'h0120];
  logic arm, prof;
  logic [1:0] mode;
  logic [2:0] ist, imask, e3;
  byte_type rq[$];
  logic [2:0] mq[$];
  int n_errors, comparisons;

  ////////////////////////////////////////////////////////////////////////////
  // Design, bus partner and clock
  dbg_cmp_match dbg_cmp_match_pc_address_select (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
    .bus_read(bus_read), .bus_addr(bus_addr), .bus_data(bus_data),
    .pc_valid(pc_valid), .pc_addr(pc_addr), .cmp_b_address(cmp_b_address),
    .prof_entry_start(prof_entry_start), .prof_tx_end(prof_tx_end),
    .match_a(match_a), .match_b(match_b), .match_range(match_range),
    .profiling_active_flag(profiling_active_flag), .irq(irq));
  cpu_bus_model cpu_bus_model_pc_address_select (.clk(clk), .bus_valid(bus_valid),
    .bus_read(bus_read), .bus_addr(bus_addr), .bus_data(bus_data),
    .pc_valid(pc_valid), .pc_addr(pc_addr));
  always #50 clk = ~clk;

  // Comparator values as software sees them, high byte at the low address
  assign aa = {sh[16'h0115], sh[16'h0116], sh[16'h0117]};
  assign ad = {sh[16'h0118], sh[16'h0119], sh[16'h011A], sh[16'h011B]};
  assign am = {sh[16'h011C], sh[16'h011D], sh[16'h011E], sh[16'h011F]};

  ////////////////////////////////////////////////////////////////////////////
  // Register write, noted in the shadow only where it may take effect
  task automatic wr(input reg_addr_type a, input byte_type d);
    logic lk;
    lk = arm | prof;
    if (a == 16'h0100 && !lk) mode = d[2:1];
    if (a == 16'h0100) arm = d[0];
    if (a == 16'h0102) ist = ist & ~d[2:0];
    if (a == 16'h0103) imask = d[2:0];
    if (!lk && a >= 16'h0115 && a <= 16'h0120)
      sh[a] = (a == 16'h0120) ? d & `B_CTRL_WMASK : d;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Register read, expected byte queued for the watcher
  task automatic rd(input reg_addr_type a);
    byte_type e;
    e = 8'h00;
    if (a >= 16'h0115 && a <= 16'h0120) e = sh[a];
    if (a == 16'h0101) e = {3'h0, prof, 3'h0, arm};
    if (a == 16'h0102) e = {5'h00, ist};
    if (a == 16'h0103) e = {5'h00, imask};
    rq.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Bus cycle with its expected {range, b, a} result queued
  task automatic access(input logic pc, input logic rdn, input bus_addr_type a,
                        input bus_data_type d);
    logic ea, eb, er, rng;
    byte_type bc;
    bc  = sh[16'h0120];
    rng = mode == `MODE_RANGE;
    ea  = arm & !pc & a == aa & ((d ^ ad) & am) == '0;
    eb  = arm & bc[0] & !rng & bc[5] == pc & a == cmp_b_address
          & (bc[5] | !bc[2] | rdn == bc[3]);
    er  = arm & rng & !pc & aa <= a & a <= cmp_b_address;
    mq.push_back({er, eb, ea});
    if (pc) cpu_bus_model_pc_address_select.pc_fetch(a);
    else cpu_bus_model_pc_address_select.data_access(rdn, a, d);
    ist = ist | {er, eb, ea};
  endtask

  // One pulse on a profiling event input
  task automatic pulse(input logic start);
    if (start) prof_entry_start <= 1'b1;
    else prof_tx_end <= 1'b1;
    @(posedge clk);
    prof_entry_start <= 1'b0;
    prof_tx_end      <= 1'b0;
    @(posedge clk);
    prof = start;
    `CHK("profiling_active_flag", prof, profiling_active_flag)
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: oldest note against each result as it appears
  always @(posedge clk) begin
    if (rd_seen) begin
      e8 = rq.pop_front();
      `CHK("reg_rdata", e8, reg_rdata)
    end
    if (bus_seen) begin
      e3 = mq.pop_front();
      `CHK("match", e3, {match_range, match_b, match_a})
    end
    rd_seen  <= reg_rd;
    bus_seen <= bus_valid | pc_valid;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #3000000;
    n_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {clk, arst_n, reg_wr, reg_rd, prof_entry_start, prof_tx_end} = '0;
    {reg_addr, reg_wdata, rd_seen, bus_seen, arm, prof, mode} = '0;
    {ist, imask, n_errors, comparisons} = '0;
    foreach (sh[i]) sh[i] = 8'h00;
    void'($urandom(32'h2780425c));
    cmp_b_address <= bus_addr_type'($urandom());
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Reset values, random bytes written and read back, unmapped places
    for (int i = 16'h0114; i <= 16'h0121; i++) rd(i[15:0]);
    for (int i = 16'h0115; i <= 16'h0120; i++) wr(i[15:0], byte_type'($urandom()));
    wr(16'h011F, sh[16'h011F] | 8'h01);
    for (int i = 16'h0114; i <= 16'h0121; i++) rd(i[15:0]);
    $display("test registers done");
    // Comparator A: masked data, every address bit, interrupt
    wr(16'h0103, 8'h07);
    wr(16'h0100, 8'h01);
    access(1'b0, 1'b1, aa, ad ^ (bus_data_type'($urandom()) & ~am));
    `CHK("irq", |(ist & imask), irq)
    access(1'b0, 1'b0, aa, ad ^ 32'h00000001);
    for (int i = 0; i < 24; i++) access(1'b0, 1'b0, aa ^ (24'h1 << i), ad);
    repeat (20) access(1'b0, 1'b1, bus_addr_type'($urandom()), ad);
    rd(16'h0102);
    wr(16'h0103, 8'h06);
    `CHK("irq", |(ist & imask), irq)
    wr(16'h0102, 8'h07);
    rd(16'h0102);
    $display("test comparator a done");
    // Writes refused while armed and while profiling runs
    wr(16'h0115, ~sh[16'h0115]);
    rd(16'h0115);
    wr(16'h0100, 8'h00);
    pulse(1'b1);
    rd(16'h0101);
    wr(16'h0116, ~sh[16'h0116]);
    wr(16'h0100, 8'h02);
    rd(16'h0116);
    pulse(1'b0);
    wr(16'h0116, ~sh[16'h0116]);
    rd(16'h0116);
    wr(16'h0115, ~sh[16'h0115]);
    rd(16'h0115);
    $display("test write lock done");
    // Comparator B over every control setting
    for (int k = 0; k < 16; k++) begin
      wr(16'h0100, 8'h00);
      wr(16'h0120, {2'h0, k[3], 1'b0, k[2], k[1], 1'b0, k[0]});
      access(1'b0, 1'b1, cmp_b_address, ad);
      wr(16'h0100, 8'h01);
      access(1'b0, 1'b1, cmp_b_address, ad);
      access(1'b0, 1'b0, cmp_b_address, ad);
      access(1'b1, 1'b0, cmp_b_address, ad);
      access(1'b0, 1'b1, cmp_b_address ^ 24'h000001, ad);
    end
    $display("test comparator b done");
    // Range mode with B control set but ignored
    wr(16'h0100, 8'h00);
    wr(16'h0120, 8'h2D);
    cmp_b_address <= aa + 24'h000010;
    wr(16'h0100, 8'h03);
    for (int o = -1; o <= 17; o++) begin
      t = aa + bus_addr_type'(o);
      access(1'b0, 1'b1, t, ad);
    end
    access(1'b1, 1'b0, cmp_b_address, ad);
    rd(16'h0102);
    $display("test range done");
    tally_and_finish();
  end
endmodule
